// ---- design/pvl_pkg.sv ----
// Package with shared constants and carrier types of the peripheral valid/ack target.
package pvl_pkg;

	localparam int PVL_ADDR_W = 32;
	localparam int PVL_BYTES = 4;
	localparam int PVL_ERR_W = 1;
	localparam int PVL_MEM_WORDS = 64;
	localparam int PVL_WAIT_STATES = 0;
	localparam int PVL_WAIT_CNT_W = 4;
	localparam logic PVL_CMD_READ = 1'h1;
	localparam logic PVL_CMD_WRITE = 1'h0;
	localparam logic PVL_ACK_RESET = 1'h0;
	localparam logic [31:0] PVL_RDATA_RESET = 32'h0;
	localparam logic [PVL_ERR_W-1:0] PVL_ERR_NONE = 1'h0;
	localparam logic [PVL_ERR_W-1:0] PVL_ERR_RANGE = 1'h1;
	localparam logic [PVL_ERR_W-1:0] PVL_ERR_BE = 1'h1;

	typedef enum {PVL_IDLE, PVL_WAIT, PVL_ACK} pvl_state_e;

	typedef struct packed {
		logic [PVL_ADDR_W-1:0] address;
		logic [PVL_BYTES-1:0] byte_enables;
		logic [8*PVL_BYTES-1:0] wdata;
		logic rd;
		logic end_of_burst;
	} pvl_req_s;

	typedef struct packed {
		logic [PVL_ERR_W-1:0] response_error;
		logic [8*PVL_BYTES-1:0] rdata;
	} pvl_rsp_s;

endpackage

// ---- design/pvl_be_check.sv ----
// Byte-enable legality check for aligned and unrestricted byte selection.
module pvl_be_check import pvl_pkg::*; #(
	parameter int BYTES = PVL_BYTES
) (
	input wire logic unrestricted_byte_select,
	input wire logic [BYTES-1:0] byte_enables,
	output logic be_legal
);
	// Aligned groups: single byte, aligned halfword, or full cell.
	function automatic logic aligned_ok(input logic [BYTES-1:0] be);
		logic ok;
		ok = 1'b0;
		if (be == {BYTES{1'b1}}) begin
			ok = 1'b1;
		end
		for (int i = 0; i < BYTES; i++) begin
			if (be == (BYTES)'(1 << i)) begin
				ok = 1'b1;
			end
		end
		for (int i = 0; i + 1 < BYTES; i += 2) begin
			if (be == (BYTES)'(3 << i)) begin
				ok = 1'b1;
			end
		end
		return ok;
	endfunction

	always_comb begin
		if (unrestricted_byte_select) begin
			be_legal = 1'b1;
		end else begin
			be_legal = aligned_ok(byte_enables);
		end
	end
endmodule

// ---- design/pvl_target.sv ----
// Peripheral valid/ack link target with a small word memory behind it.
// Summary of operation
// - Transfer completes when valid and ack high.
// - Ack combinational or registered with wait states.
// - Combinational ack uses minimal logic from valid.
// - Ack ignored while valid is low.
// - Single-cycle target may hold ack high.
// - Each handshake moves one fixed-width cell.
// - Response is ack, error and read data.
// - Request and response fields flow one way.
// - Address up to 64 (here limited to the 32-bit request carrier), data up to 32 bits.
// - Supports 8, 16, 32-bit naturally aligned cells.
// - Optional unrestricted byte-enable mode.
// - Bit zero is least significant; no endianness.
// - Reset leaves valid and ack low.
module pvl_target import pvl_pkg::*; #(
	parameter int ADDR_W = PVL_ADDR_W,
	parameter int BYTES = PVL_BYTES,
	parameter int MEM_WORDS = PVL_MEM_WORDS,
	parameter int WAIT_STATES = PVL_WAIT_STATES,
	parameter bit UNRESTRICTED_BE = 1'b0
) (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic REQUEST_VALID,
	input wire logic [ADDR_W-1:0] ADDRESS,
	input wire logic [BYTES-1:0] BYTE_ENABLES,
	input wire logic [8*BYTES-1:0] WDATA,
	input wire logic RD,
	input wire logic END_OF_BURST,
	output logic ACK,
	output logic [PVL_ERR_W-1:0] RESPONSE_ERROR,
	output logic [8*BYTES-1:0] RDATA,
	output logic BURST_DONE
);
	localparam int OFS_W = $clog2(BYTES) > 0 ? $clog2(BYTES) : 1;
	localparam int IDX_W = $clog2(MEM_WORDS);

	// cell of 1, 2 or 4 bytes.
	initial begin
		// The request carrier is only as wide as the package address width.
		if (ADDR_W < 1 || ADDR_W > 64 || ADDR_W > PVL_ADDR_W) begin
			$error("address width must be 1 to 64 and fit the request carrier");
		end
		if (BYTES > PVL_BYTES) begin
			$error("cell must fit the request carrier");
		end
		if (BYTES != 1 && BYTES != 2 && BYTES != 4) begin
			$error("cell must be 1, 2 or 4 bytes");
		end
		if (MEM_WORDS < 2 || (MEM_WORDS & (MEM_WORDS - 1)) != 0) begin
			$error("memory depth must be a power of two");
		end
		if (WAIT_STATES < 0 || WAIT_STATES > 15) begin
			$error("wait states must be 0 to 15");
		end
	end

	pvl_req_s req;
	logic [8*BYTES-1:0] mem [MEM_WORDS];
	logic be_legal;
	logic in_range;
	logic [IDX_W-1:0] word_idx;
	logic [PVL_WAIT_CNT_W-1:0] wait_cnt;
	logic ack_reg;
	logic fire;
	pvl_state_e state;

	always_comb begin
		req = '0;
		req.address[ADDR_W-1:0] = ADDRESS;
		req.byte_enables[BYTES-1:0] = BYTE_ENABLES;
		req.wdata[8*BYTES-1:0] = WDATA;
		req.rd = RD;
		req.end_of_burst = END_OF_BURST;
	end

	pvl_be_check #(
		.BYTES(BYTES)
	) u_be_check (
		.unrestricted_byte_select(UNRESTRICTED_BE),
		.byte_enables(BYTE_ENABLES),
		.be_legal(be_legal)
	);

	// cell index drops the low OFS_W bits: the byte offset, or bit 0 for a 1-byte cell.
	function automatic logic [IDX_W-1:0] cell_index(input logic [ADDR_W-1:0] a);
		return IDX_W'(a >> OFS_W);
	endfunction

	assign word_idx = cell_index(ADDRESS);
	assign in_range = (ADDRESS >> OFS_W) < ADDR_W'(MEM_WORDS);

	// combinational path is a bare wire.
	generate
		if (WAIT_STATES == 0) begin : g_fast
			assign ACK = RST_B;
		end else begin : g_slow
			assign ACK = ack_reg;
		end
	endgenerate

	assign fire = REQUEST_VALID && ACK;

	// Wait-state sequencer; a valid held after completion restarts it.
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			state <= PVL_IDLE;
			wait_cnt <= '0;
			ack_reg <= PVL_ACK_RESET;
		end else begin
			case (state)
				PVL_IDLE: begin
					ack_reg <= 1'b0;
					if (REQUEST_VALID && WAIT_STATES > 0) begin
						if (WAIT_STATES == 1) begin
							state <= PVL_ACK;
							ack_reg <= 1'b1;
						end else begin
							state <= PVL_WAIT;
							wait_cnt <= PVL_WAIT_CNT_W'(WAIT_STATES - 2);
						end
					end
				end
				PVL_WAIT: begin
					if (wait_cnt == '0) begin
						state <= PVL_ACK;
						ack_reg <= 1'b1;
					end else begin
						wait_cnt <= wait_cnt - 1'b1;
					end
				end
				PVL_ACK: begin
					ack_reg <= 1'b0;
					state <= PVL_IDLE;
				end
				default: begin
					state <= PVL_IDLE;
					ack_reg <= 1'b0;
				end
			endcase
		end
	end

	// byte lane i is bits 8i+7..8i.
	always_ff @(posedge CLK) begin
		if (fire && req.rd == PVL_CMD_WRITE && in_range && be_legal) begin
			for (int i = 0; i < BYTES; i++) begin
				if (req.byte_enables[i]) begin
					mem[word_idx][8*i +: 8] <= req.wdata[8*i +: 8];
				end
			end
		end
	end

	// response prepared so it stands with ack.
	// error and read data.
	// Registered outputs follow the request of the previous cycle, so with a
	// combinational ack the data would be one cycle late; it is therefore
	// presented combinationally from the memory in that configuration.
	pvl_rsp_s rsp_now;
	pvl_rsp_s rsp_reg;

	always_comb begin
		rsp_now.rdata = '0;
		rsp_now.response_error = PVL_ERR_NONE;
		if (!in_range) begin
			rsp_now.response_error = PVL_ERR_RANGE;
		end else if (!be_legal) begin
			rsp_now.response_error = PVL_ERR_BE;
		end else if (req.rd == PVL_CMD_READ) begin
			for (int i = 0; i < BYTES; i++) begin
				if (req.byte_enables[i]) begin
					rsp_now.rdata[8*i +: 8] = mem[word_idx][8*i +: 8];
				end
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			rsp_reg <= '0;
		end else begin
			rsp_reg <= rsp_now;
		end
	end

	generate
		if (WAIT_STATES == 0) begin : g_rsp_fast
			assign RDATA = rsp_now.rdata;
			assign RESPONSE_ERROR = rsp_now.response_error;
		end else begin : g_rsp_slow
			assign RDATA = rsp_reg.rdata;
			assign RESPONSE_ERROR = rsp_reg.response_error;
		end
	endgenerate

	// pulse on last cell of a burst.
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			BURST_DONE <= 1'b0;
		end else begin
			BURST_DONE <= fire && req.end_of_burst;
		end
	end

endmodule

// ---- dv/pvl_properties.sv ----
// Concurrent checks on the ports of the valid/ack target.
module pvl_properties import pvl_pkg::*; #(
	parameter int WAIT_STATES = PVL_WAIT_STATES,
	parameter int MEM_WORDS = PVL_MEM_WORDS
) (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic REQUEST_VALID,
	input wire logic [PVL_ADDR_W-1:0] ADDRESS,
	input wire logic RD,
	input wire logic END_OF_BURST,
	input wire logic ACK,
	input wire logic [PVL_ERR_W-1:0] RESPONSE_ERROR,
	input wire logic [8*PVL_BYTES-1:0] RDATA,
	input wire logic BURST_DONE
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_B);
	logic [3:0] waited;
	logic fire;
	logic rst_low;
	always_ff @(posedge CLK) begin
		waited <= (RST_B && REQUEST_VALID && !ACK) ? waited + 4'h1 : 4'h0;
	end
	// Reset is synchronous, so acknowledge is only checked from the second edge in reset.
	always_ff @(posedge CLK) begin
		rst_low <= !RST_B;
	end
	always_ff @(posedge CLK) begin
		fire <= REQUEST_VALID && ACK && END_OF_BURST;
	end
	sequence s_done;
		REQUEST_VALID && ACK && WAIT_STATES != 0;
	endsequence
	sequence s_quiet;
		!ACK;
	endsequence
	a_ack_after_reset: assert property (disable iff (1'b0) rst_low && !RST_B |-> !ACK)
		else $error("ack high during reset");
	a_wait_count: assert property (REQUEST_VALID && ACK |-> waited == WAIT_STATES)
		else $error("wrong wait count");
	a_ack_single: assert property (s_done |=> s_quiet)
		else $error("ack too long");
	a_ack_with_valid: assert property (WAIT_STATES != 0 && ACK |-> REQUEST_VALID && $past(REQUEST_VALID))
		else $error("ack without request");
	a_ack_bounded: assert property ($rose(REQUEST_VALID) |-> ##[1:15] ACK)
		else $error("no ack");
	a_burst_pulse: assert property (BURST_DONE == fire)
		else $error("burst flag wrong");
	a_err_range: assert property (REQUEST_VALID && ACK && ADDRESS >= PVL_BYTES * MEM_WORDS
		|-> RESPONSE_ERROR == PVL_ERR_RANGE)
		else $error("range error missing");
	a_write_rdata: assert property (REQUEST_VALID && ACK && !RD |-> RDATA == 32'h0)
		else $error("read data on write");
endmodule
bind pvl_target pvl_properties #(.WAIT_STATES(WAIT_STATES), .MEM_WORDS(MEM_WORDS)) chk_u (
	.CLK(CLK), .RST_B(RST_B), .REQUEST_VALID(REQUEST_VALID), .ADDRESS(ADDRESS), .RD(RD),
	.END_OF_BURST(END_OF_BURST), .ACK(ACK), .RESPONSE_ERROR(RESPONSE_ERROR), .RDATA(RDATA),
	.BURST_DONE(BURST_DONE));

// ---- dv/pvl_initiator.sv ----
// Initiator model that holds each request until it is acknowledged.
module pvl_initiator import pvl_pkg::*; (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic go,
	input wire pvl_req_s req,
	input wire logic ack,
	output logic valid,
	output pvl_req_s bus
);
	pvl_req_s held;
	assign bus = valid ? held : pvl_req_s'(~held);
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			valid <= 1'b0;
			held <= '0;
		end else if (go && (!valid || ack)) begin
			valid <= 1'b1;
			held <= req;
		end else if (ack) begin
			valid <= 1'b0;
		end
	end
endmodule

// ---- dv/tb.sv ----
// Self-checking bench for the valid/ack target.
module tb import pvl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK = 1'b0, RST_B = 1'b0, go = 1'b0, valid, ack, bd;
	logic [31:0] rdata;
	logic [0:0] rerr;
	logic ack_f, bd_f;
	logic [31:0] rdata_f;
	logic [0:0] rerr_f;
	pvl_req_s req = '0, bus;
	int failures = 0, samples_checked = 0;
	always #4 CLK = ~CLK;
	pvl_initiator part_u (.CLK(CLK), .RST_B(RST_B), .go(go), .req(req), .ack(ack),
		.valid(valid), .bus(bus));
	pvl_target #(.WAIT_STATES(2)) dut_u (.CLK(CLK), .RST_B(RST_B), .REQUEST_VALID(valid),
		.ADDRESS(bus.address), .BYTE_ENABLES(bus.byte_enables), .WDATA(bus.wdata), .RD(bus.rd),
		.END_OF_BURST(bus.end_of_burst), .ACK(ack), .RESPONSE_ERROR(rerr), .RDATA(rdata),
		.BURST_DONE(bd));
	// A zero-wait target on the same request bus takes every held cycle as a new cell.
	pvl_target #(.WAIT_STATES(0)) dut_fast_u (.CLK(CLK), .RST_B(RST_B), .REQUEST_VALID(valid),
		.ADDRESS(bus.address), .BYTE_ENABLES(bus.byte_enables), .WDATA(bus.wdata), .RD(bus.rd),
		.END_OF_BURST(bus.end_of_burst), .ACK(ack_f), .RESPONSE_ERROR(rerr_f), .RDATA(rdata_f),
		.BURST_DONE(bd_f));
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	function automatic pvl_req_s mk(logic [31:0] a, logic [3:0] be, logic [31:0] d, logic r,
		logic e);
		return '{a, be, d, r, e};
	endfunction
	// Cells are issued back to back: the next one waits in req while go stays high.
	task automatic run(input pvl_req_s rq[$], input logic [32:0] ex[$]);
		int n;
		@(posedge CLK);
		go <= 1'b1;
		req <= rq[0];
		@(posedge CLK);
		foreach (rq[i]) begin
			if (i + 1 < rq.size()) req <= rq[i + 1];
			else go <= 1'b0;
			n = 0;
			do begin
				@(negedge CLK);
				n++;
			end while ((valid & ack) !== 1'b1 && n < 20);
			if (n >= 20) begin
				failures++;
				tally_and_finish();
			end
			check({rerr, rdata}, ex[i]);
			check({rerr_f, rdata_f}, ex[i]);
			@(posedge CLK);
		end
	endtask
	task automatic t_word;
		run({mk(32'h10, 4'hF, 32'hA5C31E7F, PVL_CMD_WRITE, 1'b0),
			mk(32'h10, 4'hF, 32'h0, PVL_CMD_READ, 1'b1)}, {33'h0, 33'h0A5C31E7F});
		@(negedge CLK);
		check(33'(bd), 33'h1);
		check(33'(bd_f), 33'h1);
		$display("word test done");
	endtask
	task automatic t_lanes;
		run({mk(32'h10, 4'h2, 32'h11223344, PVL_CMD_WRITE, 1'b0),
			mk(32'h10, 4'h5, 32'h0, PVL_CMD_WRITE, 1'b0),
			mk(32'h10, 4'hC, 32'h0, PVL_CMD_READ, 1'b0),
			mk(32'h10, 4'h3, 32'h0, PVL_CMD_READ, 1'b1)},
			{33'h0, 33'h100000000, 33'h0A5C30000, 33'h00000337F});
		$display("lane test done");
	endtask
	task automatic t_range;
		run({mk(32'hFC, 4'hF, 32'h5A5A0F0F, PVL_CMD_WRITE, 1'b0),
			mk(32'hFC, 4'hF, 32'h0, PVL_CMD_READ, 1'b0),
			mk(32'h100, 4'hF, 32'h0, PVL_CMD_READ, 1'b0),
			mk(32'h100, 4'hF, 32'h1, PVL_CMD_WRITE, 1'b1)},
			{33'h0, 33'h05A5A0F0F, 33'h100000000, 33'h100000000});
		$display("range test done");
	endtask
	initial begin
		repeat (8) @(posedge CLK);
		@(negedge CLK);
		check(33'(ack), 33'h0);
		check(33'(ack_f), 33'h0);
		@(posedge CLK);
		RST_B <= 1'b1;
		@(negedge CLK);
		check(33'(ack_f), 33'h1);
		t_word();
		t_lanes();
		t_range();
		tally_and_finish();
	end
endmodule
